// ===== pkg/kbsc_cfg.svh
`ifndef KBSC_CFG_SVH
`define KBSC_CFG_SVH
// Functional notes
// - twenty keys, 4x4 matrix plus four extras
// - result is group bit plus 4-bit position
// - idle drives rows low, column low detects
// - scan captures row/column code into holding register
// - group high unless an extra key pressed
// - encoding autonomous; host read starts transfer
// - captured code raises pending, keypad interrupt source
// - host read enables code and group transfer
// - pending rise sets keypad latch; host clears
// - merge bus, measurement, keypad requests
// - standby key sets standby latch and flag
// - standby latch rise toggles power state
// - standby: shutdown, indicator, block merged requests
// - host clears standby latch; power state kept
// - standby holds host interrupt high, bus reset
// - wake: supplies back, delayed interrupt enable
// - reset host and bus on power change

// clock and timing
`define KBSC_CLK_PERIOD_NS 10
`define KBSC_WAKE_DELAY_US 100
`define KBSC_WAKE_CYC ((`KBSC_WAKE_DELAY_US * 1000) / `KBSC_CLK_PERIOD_NS)
`define KBSC_PWR_RST_MS 300
`define KBSC_PWR_RST_CYC ((`KBSC_PWR_RST_MS * 1000000) / `KBSC_CLK_PERIOD_NS)
`define KBSC_SETTLE_CYC 3

// register byte offsets
`define KBSC_OFF_STATUS 12'h000
`define KBSC_OFF_KEYCODE 12'h004
`define KBSC_OFF_CLEAR 12'h008
`define KBSC_OFF_CTRL 12'h00C

// status fields
`define KBSC_ST_KBD 0
`define KBSC_ST_STBY 1
`define KBSC_ST_POWER 2
`define KBSC_ST_PEND 3
`define KBSC_ST_IRQEN 4
`define KBSC_ST_IRQ 5
`define KBSC_ST_MEAS 6
`define KBSC_ST_BUS 7
// keycode fields
`define KBSC_KC_GROUP 4
// clear fields
`define KBSC_CLR_KBD 0
`define KBSC_CLR_STBY 1
// control fields: source enables
`define KBSC_CTL_KBD 0
`define KBSC_CTL_MEAS 1
`define KBSC_CTL_BUS 2
`define KBSC_CTL_RST 3'h7
// synchroniser reset: power,bus,meas low; key lines high
`define KBSC_SYNC_RST 9'h03F
`endif

// ===== pkg/kbsc_pkg.sv
package kbsc_pkg;
  // encoder scan states, one-hot
  typedef enum logic [4:0] {
    KBSC_IDLE = 5'h01,
    KBSC_SETTLE = 5'h02,
    KBSC_SAMPLE = 5'h04,
    KBSC_HOLD = 5'h08,
    KBSC_RELEASE = 5'h10
  } kbsc_scan_state_t;
  typedef logic [3:0] kbsc_code_t;
endpackage

// ===== pkg/kbsc_key_if.sv
`timescale 1ns/1ps
// encoder result toward the interrupt logic
interface kbsc_key_if;
  logic [3:0] code;
  logic group;
  logic pending;
  logic clear;
  modport enc (output code, output group, output pending, input clear);
  modport ctl (input code, input group, input pending, output clear);
endinterface

// ===== logic/kbsc_scan.sv
`timescale 1ns/1ps
`include "kbsc_cfg.svh"
module kbsc_scan import kbsc_pkg::*; #(
  parameter int unsigned ROWS = 4,
  parameter int unsigned COLS = 4,
  parameter int unsigned SETTLE = `KBSC_SETTLE_CYC
) (
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // keypad lines, already synchronised
  output logic [ROWS-1:0] row_o,
  input wire logic [COLS-1:0] col_n_i,
  input wire logic ext_n_i,
  // result toward the controller
  kbsc_key_if.enc key
);
  // refuse geometry and settle counts the scan cannot serve
  if (ROWS != 4 || COLS != 4 || SETTLE < 3 || SETTLE > 15) begin : g_bad_cfg
    $error("kbsc_scan: unsupported geometry or settle count");
  end

  kbsc_scan_state_t state_reg;
  kbsc_scan_state_t state_next;
  logic [1:0] row_reg;
  logic [3:0] cnt_reg;
  kbsc_code_t code_reg;
  logic group_reg;

  // first low column, lowest index wins
  function automatic logic [1:0] first_low(input logic [COLS-1:0] c);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = COLS - 1; i >= 0; i--) begin
      if (!c[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction

  // detection wires
  wire logic col_hit = ~&col_n_i;
  wire logic ext_hit = ~ext_n_i;
  wire logic any_hit = col_hit | ext_hit;
  wire logic scanning = (state_reg == KBSC_SETTLE) || (state_reg == KBSC_SAMPLE);
  wire logic last_row = (row_reg == 2'(ROWS - 1));
  wire logic settled = (cnt_reg == 4'(SETTLE - 1));
  // matrix code from row and column
  wire kbsc_code_t mat_code = {row_reg, first_low(col_n_i)};
  // extra keys sit on rows, code is the row
  wire kbsc_code_t ext_code = {2'h0, row_reg};

  // rows all low while idle, one row low while scanning
  assign row_o = scanning ? ~(ROWS'(1) << row_reg) : '0;
  assign key.code = code_reg;
  assign key.group = group_reg;
  assign key.pending = (state_reg == KBSC_HOLD);

  // next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      KBSC_IDLE: if (any_hit) state_next = KBSC_SETTLE;
      KBSC_SETTLE: if (settled) state_next = KBSC_SAMPLE;
      KBSC_SAMPLE: begin
        if (any_hit) state_next = KBSC_HOLD;
        else if (last_row) state_next = KBSC_IDLE;
        else state_next = KBSC_SETTLE;
      end
      KBSC_HOLD: if (key.clear) state_next = KBSC_RELEASE;
      KBSC_RELEASE: if (!any_hit) state_next = KBSC_IDLE;
      default: state_next = KBSC_IDLE;
    endcase
  end

  // scan state, row pointer, settle counter
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= KBSC_IDLE;
      row_reg <= 2'h0;
      cnt_reg <= 4'h0;
    end else if (clk_en_i) begin
      state_reg <= state_next;
      cnt_reg <= (state_reg == KBSC_SETTLE) ? cnt_reg + 4'h1 : 4'h0;
      if (state_reg == KBSC_IDLE) row_reg <= 2'h0;
      else if (state_reg == KBSC_SAMPLE && !any_hit) row_reg <= row_reg + 2'h1;
    end
  end

  // capture code; group low only for extra key
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_reg <= 4'h0;
      group_reg <= 1'b1;
    end else if (clk_en_i) begin
      if (state_reg == KBSC_SAMPLE && any_hit) begin
        code_reg <= col_hit ? mat_code : ext_code;
        group_reg <= col_hit;
      end else if (state_reg == KBSC_HOLD && key.clear) begin
        group_reg <= 1'b1;
      end
    end
  end
endmodule

// ===== logic/kbsc_top.sv
`timescale 1ns/1ps
`include "kbsc_cfg.svh"
module kbsc_top import kbsc_pkg::*; #(
  parameter int unsigned WAKE_CYC = `KBSC_WAKE_CYC,
  parameter int unsigned PWR_RST_CYC = `KBSC_PWR_RST_CYC
) (
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // apb slave
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // keypad
  output logic [3:0] row_o,
  input wire logic [3:0] col_n_i,
  input wire logic ext_n_i,
  output logic key_group_o,
  output logic key_pending_o,
  // standby key and power sense
  input wire logic standby_key_n_i,
  input wire logic power_ok_i,
  // interrupt sources
  input wire logic measurement_interrupt_i,
  input wire logic bus_irq_i,
  // host and system outputs
  output logic host_irq_n_o,
  output logic host_reset_o,
  output logic bus_reset_o,
  output logic supply_shutdown_o,
  output logic standby_led_o
);
  // refuse delay counts the counters cannot serve
  if (WAKE_CYC < 1 || PWR_RST_CYC < 1) begin : g_bad_delay
    $error("kbsc_top: delay counts must be at least one cycle");
  end

  kbsc_key_if key ();

  // rising edge of a sampled level
  function automatic logic rise(input logic prev, input logic cur);
    return cur & ~prev;
  endfunction

  // two-flop synchronisers for every pin input
  logic [8:0] sync1_reg;
  logic [8:0] sync2_reg;
  wire logic [8:0] pins = {power_ok_i, bus_irq_i, measurement_interrupt_i, standby_key_n_i, ext_n_i, col_n_i};
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_reg <= `KBSC_SYNC_RST;
      sync2_reg <= `KBSC_SYNC_RST;
    end else if (clk_en_i) begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end

  // synchronised levels
  wire logic [3:0] col_s = sync2_reg[3:0];
  wire logic ext_s = sync2_reg[4];
  wire logic stby_key_s = ~sync2_reg[5];
  wire logic meas_s = sync2_reg[6];
  wire logic bus_s = sync2_reg[7];
  wire logic pwr_s = sync2_reg[8];

  // keypad encoder
  kbsc_scan u_scan (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .row_o(row_o),
    .col_n_i(col_s),
    .ext_n_i(ext_s),
    .key(key.enc)
  );

  // state registers
  logic kbd_latch_reg;
  logic stby_latch_reg;
  logic power_reg;
  logic irq_en_reg;
  logic [31:0] wake_cnt_reg;
  logic [31:0] prst_cnt_reg;
  logic [2:0] src_en_reg;
  logic [31:0] prdata_reg;
  logic rd_ok_reg;
  logic host_irq_n_reg;
  logic host_reset_reg;
  logic bus_reset_reg;

  // edge history
  logic stby_prev_reg;
  logic pwr_prev_reg;
  logic pend_prev_reg;
  logic slatch_prev_reg;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stby_prev_reg <= 1'b0;
      pwr_prev_reg <= 1'b0;
      pend_prev_reg <= 1'b0;
      slatch_prev_reg <= 1'b0;
    end else if (clk_en_i) begin
      stby_prev_reg <= stby_key_s;
      pwr_prev_reg <= pwr_s;
      pend_prev_reg <= key.pending;
      slatch_prev_reg <= stby_latch_reg;
    end
  end

  // one event per press or request edge
  wire logic stby_press = rise(stby_prev_reg, stby_key_s);
  wire logic pend_rise = rise(pend_prev_reg, key.pending);
  wire logic stby_rise = rise(slatch_prev_reg, stby_latch_reg);
  wire logic pwr_edge = pwr_s ^ pwr_prev_reg;

  // apb decode
  wire logic setup = psel_i & ~penable_i;
  wire logic access = psel_i & penable_i & pready_o;
  wire logic wr_acc = access & pwrite_i;
  wire logic sel_status = (paddr_i == `KBSC_OFF_STATUS);
  wire logic sel_keycode = (paddr_i == `KBSC_OFF_KEYCODE);
  wire logic sel_clear = (paddr_i == `KBSC_OFF_CLEAR);
  wire logic sel_ctrl = (paddr_i == `KBSC_OFF_CTRL);
  wire logic mapped = sel_status | sel_keycode | sel_clear | sel_ctrl;
  wire logic clr_kbd = wr_acc & sel_clear & pwdata_i[`KBSC_CLR_KBD];
  wire logic clr_stby = wr_acc & sel_clear & pwdata_i[`KBSC_CLR_STBY];
  wire logic ctrl_wr = wr_acc & sel_ctrl;
  // key-code enable is the host read of the keycode register
  wire logic key_oe = setup & ~pwrite_i & sel_keycode;

  // encoder released only by the host clear
  assign key.clear = clr_kbd & clk_en_i;

  wire logic merged = (kbd_latch_reg & src_en_reg[`KBSC_CTL_KBD])
    | (meas_s & src_en_reg[`KBSC_CTL_MEAS])
    | (bus_s & src_en_reg[`KBSC_CTL_BUS]);
  wire logic gated = merged & ~power_reg;
  // no request while interrupt input disabled
  wire logic irq_req = irq_en_reg & (gated | stby_latch_reg);
  wire logic wake_busy = (wake_cnt_reg != 32'h0000_0000);
  wire logic prst_busy = (prst_cnt_reg != 32'h0000_0000);

  // read mux
  wire logic [31:0] status_word = {24'h00_0000, bus_s, meas_s, ~host_irq_n_reg, irq_en_reg,
    key.pending, power_reg, stby_latch_reg, kbd_latch_reg};
  // code and group placed on the bus while enabled
  wire logic [31:0] keycode_word = key_oe ? {27'h000_0000, key.group, key.code} : 32'h0000_0000;
  wire logic [31:0] rd_word = sel_status ? status_word
    : sel_keycode ? keycode_word
    : sel_ctrl ? {29'h0000_0000, src_en_reg} : 32'h0000_0000;

  // apb read data captured in setup, write side in access
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_reg <= 32'h0000_0000;
      rd_ok_reg <= 1'b0;
      src_en_reg <= `KBSC_CTL_RST;
    end else if (clk_en_i) begin
      if (setup) begin
        prdata_reg <= rd_word;
      end
      rd_ok_reg <= setup & ~pwrite_i;
      if (ctrl_wr) begin
        src_en_reg <= pwdata_i[2:0];
      end
    end
  end

  // keypad latch, set wins over clear
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      kbd_latch_reg <= 1'b0;
    end else if (clk_en_i) begin
      if (pend_rise) kbd_latch_reg <= 1'b1;
      else if (clr_kbd) kbd_latch_reg <= 1'b0;
    end
  end

  // standby latch set per press; host clear, set wins
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stby_latch_reg <= 1'b0;
    end else if (clk_en_i) begin
      if (stby_press) stby_latch_reg <= 1'b1;
      else if (clr_stby) stby_latch_reg <= 1'b0;
    end
  end

  // power state toggles on standby latch rise only
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_reg <= 1'b0;
    end else if (clk_en_i) begin
      if (stby_rise) power_reg <= ~power_reg;
    end
  end

  // wake delay before the interrupt input reopens
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_cnt_reg <= 32'h0000_0000;
      irq_en_reg <= 1'b1;
    end else if (clk_en_i) begin
      if (stby_rise && !power_reg) begin
        // entering standby closes the interrupt input
        wake_cnt_reg <= 32'h0000_0000;
        irq_en_reg <= 1'b0;
      end else if (stby_rise && power_reg) begin
        wake_cnt_reg <= 32'(WAKE_CYC);
        irq_en_reg <= 1'b0;
      end else if (wake_busy) begin
        wake_cnt_reg <= wake_cnt_reg - 32'h0000_0001;
        irq_en_reg <= (wake_cnt_reg == 32'h0000_0001);
      end
    end
  end

  // host reset pulse after release and each power change
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prst_cnt_reg <= 32'(PWR_RST_CYC);
    end else if (clk_en_i) begin
      if (pwr_edge) prst_cnt_reg <= 32'(PWR_RST_CYC);
      else if (prst_busy) prst_cnt_reg <= prst_cnt_reg - 32'h0000_0001;
    end
  end

  // registered pin outputs
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_irq_n_reg <= 1'b1;
      host_reset_reg <= 1'b1;
      bus_reset_reg <= 1'b1;
    end else if (clk_en_i) begin
      // active low request, high while disabled
      host_irq_n_reg <= ~irq_req;
      host_reset_reg <= prst_busy;
      // bus interface held in reset through standby and wake
      bus_reset_reg <= prst_busy | power_reg | ~irq_en_reg;
    end
  end

  // apb answers: no wait states, reads after a setup cycle
  assign pready_o = clk_en_i & (pwrite_i | rd_ok_reg);
  assign pslverr_o = psel_i & penable_i & ~mapped;
  assign prdata_o = prdata_reg;
  // group bit high unless an extra key is held
  assign key_group_o = key.group;
  assign key_pending_o = key.pending;
  assign host_irq_n_o = host_irq_n_reg;
  assign host_reset_o = host_reset_reg;
  assign bus_reset_o = bus_reset_reg;
  // shutdown request and indicator follow power state
  assign supply_shutdown_o = power_reg;
  assign standby_led_o = power_reg;
endmodule

// ===== dv/kbsc_asserts.sv
`timescale 1ns/1ps
`include "kbsc_cfg.svh"
module kbsc_asserts (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // apb
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // keypad
  input wire logic [3:0] row_o,
  input wire logic key_group_o,
  input wire logic key_pending_o,
  // power and host
  input wire logic power_ok_i,
  input wire logic host_irq_n_o,
  input wire logic host_reset_o,
  input wire logic bus_reset_o,
  input wire logic supply_shutdown_o,
  input wire logic standby_led_o
);
  default clocking dcb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // access phase and keypad clear decode
  wire logic acc = psel_i && penable_i;
  wire logic kclr = acc && pwrite_i && pready_o && paddr_i == `KBSC_OFF_CLEAR && pwdata_i[`KBSC_CLR_KBD];
  // rows idle low or one row scanned
  a_row_scan: assert property ((row_o == 4'h0) || $onehot(~row_o))
    else $error("row lines neither idle nor single scan");
  // group high while no code held
  a_group_idle: assert property (!key_pending_o && !$past(key_pending_o) |-> key_group_o)
    else $error("group low with no code held");
  // held code survives until host clear
  a_pending_holds: assert property (key_pending_o && !kclr |=> key_pending_o)
    else $error("pending dropped without clear");
  a_irq_from_key: assert property ($rose(key_pending_o) && !supply_shutdown_o |-> ##[1:4] !host_irq_n_o)
    else $error("key capture gave no host interrupt");
  a_led_tracks: assert property (standby_led_o == supply_shutdown_o)
    else $error("indicator differs from shutdown");
  // standby silences host and holds bus reset
  a_standby_quiet: assert property (supply_shutdown_o [*3] |-> host_irq_n_o && bus_reset_o)
    else $error("request or bus active in standby");
  a_wake_delay: assert property ($fell(supply_shutdown_o) |-> (bus_reset_o && host_irq_n_o) [*4] ##[1:20] !bus_reset_o)
    else $error("wake release not delayed or missing");
  a_power_reset: assert property ($changed(power_ok_i) && clk_en_i |-> ##[1:5] host_reset_o)
    else $error("no host reset on power change");
  // bus held in reset with host
  a_bus_with_host: assert property (host_reset_o |-> bus_reset_o)
    else $error("bus reset missing during host reset");
  // zero-wait answer in access phase
  a_ready_now: assert property (acc && clk_en_i |-> pready_o)
    else $error("pready low in access phase");
  // main scenarios
  c_extra_key: cover property ($rose(key_pending_o) && !key_group_o);
  c_enter: cover property ($rose(supply_shutdown_o));
  c_leave: cover property ($fell(supply_shutdown_o));
  c_error: cover property (acc && pslverr_o);
endmodule

// ===== dv/kbsc_keypad_model.sv
`timescale 1ns/1ps
module kbsc_keypad_model (
  // rows from the encoder
  input wire logic [3:0] row_i,
  // key chosen by the bench
  input wire logic press_i,
  input wire logic ext_i,
  input wire logic [1:0] prow_i,
  input wire logic [1:0] pcol_i,
  // sense lines, pulled high while open
  output logic [3:0] col_n_o,
  output logic ext_n_o
);
  // contact only while its row is driven low
  wire logic hit = press_i && !row_i[prow_i];
  // matrix keys pull a column, extra keys the extra line
  assign col_n_o = ~({3'h0, hit && !ext_i} << pcol_i);
  assign ext_n_o = !(hit && ext_i);
endmodule

// ===== dv/tb.sv
`timescale 1ns/1ps
`include "kbsc_cfg.svh"
`define CHK(nm, x, s) begin checks_done++; if ((s) !== (x)) begin fails++; $display("[ERR] %s exp %h got %h", nm, x, s); end end
`define WAIT(c) while (!(c)) @(posedge sys_clk_i);
module tb;
  // driven inputs
  logic sys_clk_i = 1'h0, rst_n_i = 1'h0, clk_en_i = 1'h1;
  logic psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic standby_key_n_i = 1'h1, power_ok_i = 1'h1, measurement_interrupt_i = 1'h0, bus_irq_i = 1'h0;
  logic press = 1'h0, ext = 1'h0;
  logic [1:0] prow = 2'h0, pcol = 2'h0;
  // design outputs and keypad lines
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, ext_n_i, key_group_o, key_pending_o;
  logic [3:0] row_o, col_n_i;
  logic host_irq_n_o, host_reset_o, bus_reset_o, supply_shutdown_o, standby_led_o;
  // bench state
  logic [31:0] q;
  logic e;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  // key rows: ext, row, col beside group, code
  logic [9:0] key_tab [9] = '{10'h010, 10'h073, 10'h0D6, 10'h139, 10'h15A, 10'h19C, 10'h1FF, 10'h200, 10'h383};
  kbsc_top #(.WAKE_CYC(8), .PWR_RST_CYC(16)) kbsc_top_i (.*);
  kbsc_keypad_model kbsc_keypad_model_i (.row_i(row_o), .press_i(press), .ext_i(ext), .prow_i(prow),
    .pcol_i(pcol), .col_n_o(col_n_i), .ext_n_o(ext_n_i));
  // 100 MHz clock
  always #5 sys_clk_i = ~sys_clk_i;
  // hang guard
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 10000) begin
      fails++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'h1;
    @(posedge sys_clk_i);
    `WAIT(pready_o === 1'h1)
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    @(posedge sys_clk_i);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
    apb(1'h0, a, 32'h0000_0000);
    `CHK(nm, x, q)
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  // press a key and wait for the held code
  task automatic hit(input logic [9:0] t);
    {ext, prow, pcol} <= t[9:5];
    press <= 1'h1;
    `WAIT(key_pending_o === 1'h1)
    repeat (3) @(posedge sys_clk_i);
    `CHK("key irq", 1'h0, host_irq_n_o)
  endtask
  task automatic stby_key;
    standby_key_n_i <= 1'h0;
    repeat (4) @(posedge sys_clk_i);
    standby_key_n_i <= 1'h1;
  endtask
  task automatic do_reset;
    rst_n_i <= 1'h0;
    repeat (8) @(posedge sys_clk_i);
    `CHK("host reset", 1'h1, host_reset_o)
    `CHK("pending", 1'h0, key_pending_o)
    `CHK("rows", 4'h0, row_o)
    rst_n_i <= 1'h1;
    `WAIT(host_reset_o === 1'h0)
  endtask
  initial begin
    do_reset();
    rd(`KBSC_OFF_CTRL, 32'h0000_0007, "ctrl reset");
    for (int i = 0; i < 9; i++) begin
      hit(key_tab[i]);
      `CHK("group pin", key_tab[i][4], key_group_o)
      rd(`KBSC_OFF_STATUS, 32'h0000_0039, "status key");
      rd(`KBSC_OFF_KEYCODE, {27'h000_0000, key_tab[i][4:0]}, "keycode");
      press <= 1'h0;
      wr(`KBSC_OFF_CLEAR, 32'h0000_0001);
      repeat (3) @(posedge sys_clk_i);
      `CHK("irq cleared", 1'h1, host_irq_n_o)
      `CHK("group idle", 1'h1, key_group_o)
    end
    // second press while a code is held, then reset mid-run
    hit(key_tab[2]);
    press <= 1'h0;
    repeat (4) @(posedge sys_clk_i);
    {ext, prow, pcol} <= 5'h0C;
    press <= 1'h1;
    repeat (30) @(posedge sys_clk_i);
    rd(`KBSC_OFF_KEYCODE, {27'h000_0000, key_tab[2][4:0]}, "code kept");
    press <= 1'h0;
    do_reset();
    // merge and masking of level sources
    for (int s = 0; s < 4; s++) begin
      wr(`KBSC_OFF_CTRL, s[0] ? 32'h0000_0007 : 32'h0000_0001);
      {measurement_interrupt_i, bus_irq_i} <= s[1] ? 2'h2 : 2'h1;
      repeat (5) @(posedge sys_clk_i);
      `CHK("merged irq", !s[0], host_irq_n_o)
      rd(`KBSC_OFF_STATUS, {24'h00_0000, !s[1], s[1], s[0], 5'h10}, "source status");
      {measurement_interrupt_i, bus_irq_i} <= 2'h0;
      repeat (5) @(posedge sys_clk_i);
      `CHK("irq idle", 1'h1, host_irq_n_o)
    end
    // refused accesses
    apb(1'h0, 12'h010, 32'h0000_0000);
    `CHK("unmapped data", 32'h0000_0000, q)
    `CHK("unmapped err", 1'h1, e)
    wr(`KBSC_OFF_STATUS, 32'h0000_00FF);
    rd(`KBSC_OFF_STATUS, 32'h0000_0010, "status ro");
    stby_key();
    `WAIT(supply_shutdown_o === 1'h1)
    repeat (4) @(posedge sys_clk_i);
    `CHK("indicator", 1'h1, standby_led_o)
    `CHK("shutdown", 1'h1, supply_shutdown_o)
    `CHK("bus reset", 1'h1, bus_reset_o)
    rd(`KBSC_OFF_STATUS, 32'h0000_0006, "standby flag");
    measurement_interrupt_i <= 1'h1;
    repeat (5) @(posedge sys_clk_i);
    `CHK("blocked irq", 1'h1, host_irq_n_o)
    wr(`KBSC_OFF_CLEAR, 32'h0000_0002);
    rd(`KBSC_OFF_STATUS, 32'h0000_0044, "power kept");
    measurement_interrupt_i <= 1'h0;
    stby_key();
    `WAIT(supply_shutdown_o === 1'h0)
    `CHK("bus reset held", 1'h1, bus_reset_o)
    `WAIT(bus_reset_o === 1'h0)
    repeat (4) @(posedge sys_clk_i);
    `CHK("wake irq", 1'h0, host_irq_n_o)
    rd(`KBSC_OFF_STATUS, 32'h0000_0032, "wake status");
    wr(`KBSC_OFF_CLEAR, 32'h0000_0002);
    repeat (3) @(posedge sys_clk_i);
    `CHK("wake cleared", 1'h1, host_irq_n_o)
    for (int p = 0; p < 2; p++) begin
      power_ok_i <= p[0];
      repeat (6) @(posedge sys_clk_i);
      `CHK("power reset", 1'h1, host_reset_o)
      `CHK("power bus reset", 1'h1, bus_reset_o)
      `WAIT(host_reset_o === 1'h0)
    end
    // clock enable low freezes the standby key path
    clk_en_i <= 1'h0;
    standby_key_n_i <= 1'h0;
    repeat (6) @(posedge sys_clk_i);
    standby_key_n_i <= 1'h1;
    repeat (3) @(posedge sys_clk_i);
    clk_en_i <= 1'h1;
    repeat (8) @(posedge sys_clk_i);
    `CHK("frozen standby", 1'h0, supply_shutdown_o)
    `CHK("frozen irq", 1'h1, host_irq_n_o)
    stop_test();
  end
endmodule
bind kbsc_top kbsc_asserts kbsc_asserts_i (.*);
